/* adcods_monitor.sv */
// Checker for the output side of the ADC output data stage.
// Assumes it is bound to adcods_output_stage and sees only its ports.
`timescale 1ns/10ps
module adcods_monitor
    import adcods_pkg::*;
(
    // Clock, reset and sample handshake.
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic              adcReady,
    // Output bus.
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic [DATA_W-1:0] dataOutOe_n,
    input wire logic              outValid,
    input wire logic              outReady
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_hold; outValid && !outReady |=> outValid && $stable(dataOut); endproperty
    a_hold: assert property (p_hold)
        else $error("output word lost while stalled");
    property p_load; $changed(dataOut) |-> outValid; endproperty
    a_load: assert property (p_load)
        else $error("output word changed without a capture");
    property p_keep; outValid && outReady ##1 !outValid |-> $stable(dataOut); endproperty
    a_keep: assert property (p_keep)
        else $error("output word changed after it was taken");
    property p_full; !adcReady |-> ##[0:5] outValid; endproperty
    a_full: assert property (p_full)
        else $error("full buffer never captured");
    property p_oe; dataOutOe_n == '0 || dataOutOe_n == '1; endproperty
    a_oe: assert property (p_oe)
        else $error("output enables disagree");
endmodule : adcods_monitor
bind adcods_output_stage adcods_monitor u_mon (.mclk(mclk), .nrst(nrst), .adcReady(adcReady), .dataOut(dataOut),
    .dataOutOe_n(dataOutOe_n), .outValid(outValid), .outReady(outReady));

/* adcods_output_stage.sv */
// ADC output data stage: buffers converter samples, latches them at a programmable phase,
// optionally Gray-codes them and drives a three-state parallel bus; AXI4-Lite control.
// Assumes samples and all inputs are synchronous to mclk; the pixel period spans four mclk cycles.
//
// Behaviour
// - Each sample is captured into the output latch at the programmed pixel-clock phase before it is driven.
// - Control bit 4 set to 1 makes the latch transparent so results pass without waiting for the phase.
// - Control bit 3 set to 1 releases every data output to high impedance so no level is driven.
// - Output coding is straight binary by default and Gray for every word captured while control bit 5 is 1.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps

module adcods_output_stage
    import adcods_pkg::*;
(
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              nrst,
    // Converter samples.
    input  wire logic [DATA_W-1:0] adcData,
    input  wire logic              adcValid,
    output logic                   adcReady,
    // Parallel output bus.
    output logic [DATA_W-1:0]      dataOut,
    output logic [DATA_W-1:0]      dataOutOe_n,
    output logic                   outValid,
    input  wire logic              outReady,
    // AXI4-Lite slave.
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // All state of the stage in one record, registered as a whole.
    typedef struct packed {
        logic [2:0]                  ctrl;       // {gray, transparent, tristate}
        logic [PHASE_W-1:0]          phase;
        logic [2:0]                  phaseCnt;
        logic [1:0][DATA_W-1:0]      mem;
        logic                        wrPtr;
        logic                        rdPtr;
        logic [1:0]                  count;
        logic                        adcReady;
        logic [DATA_W-1:0]           dataOut;
        logic                        outValid;
        logic                        hiZ;
        logic                        awHave;
        logic [3:0]                  awAddr;
        logic                        wHave;
        logic [31:0]                 wData;
        logic [3:0]                  wStrb;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
    } adcods_state_t;

    adcods_state_t st_reg;
    adcods_state_t st_next;

    function automatic logic [DATA_W-1:0] adcods_gray(input logic [DATA_W-1:0] bin);
        adcods_gray = bin ^ (bin >> 1);
    endfunction : adcods_gray

    function automatic logic [DATA_W-1:0] adcods_encode(input logic [DATA_W-1:0] bin, input logic useGray);
        adcods_encode = useGray ? adcods_gray(bin) : bin;
    endfunction : adcods_encode

    // Registers are whole aligned words, so the two low address bits take no part in the decode.
    function automatic logic adcods_hit(input logic [3:0] addr, input logic [3:0] offset);
        adcods_hit = ({addr[3:2], 2'h0} == offset);
    endfunction : adcods_hit

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Decode strobes, every one assigned on every path of the next-state process.
    logic                push;
    logic                pop;
    logic                phaseHit;
    logic                doWrite;
    logic                hitCtrl;
    logic                hitPhase;
    logic                hitStatus;

    always_comb begin
        // Every field holds its value unless a branch below moves it.
        st_next = st_reg;

        // Pixel-period phase counter; every cycle of the period is one selectable phase.
        // The period restarts at every reset, so phase 0 is the cycle of the first edge after release.
        st_next.phaseCnt = (st_reg.phaseCnt == PHASE_STEPS_M1) ? 3'h0 : st_reg.phaseCnt + 3'h1;
        phaseHit = (st_reg.phaseCnt == {1'b0, st_reg.phase});

        // Two-entry sample buffer; a stalled receiver leaves samples queued, never dropped.
        push = adcValid && st_reg.adcReady;
        pop  = (st_reg.count != 2'h0) && (!st_reg.outValid || outReady)
               && (st_reg.ctrl[CTRL_TRANSPARENT_BIT-3] || phaseHit);
        if (push) begin
            st_next.mem[st_reg.wrPtr] = adcData;
            st_next.wrPtr = ~st_reg.wrPtr;
        end
        // Coding is applied at capture, so a later mode change never alters a word already on the bus.
        if (pop) begin
            st_next.rdPtr = ~st_reg.rdPtr;
            st_next.dataOut = adcods_encode(st_reg.mem[st_reg.rdPtr], st_reg.ctrl[CTRL_GRAY_BIT-3]);
            st_next.outValid = 1'b1;
        end else if (outReady) begin
            st_next.outValid = 1'b0;
        end
        st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
        // Ready is registered from the next count, so a full buffer refuses the very next sample.
        st_next.adcReady = (st_next.count != 2'h2);
        // Releasing the bus moves only the enables, one cycle after the control write lands.
        st_next.hiZ = st_reg.ctrl[CTRL_TRISTATE_BIT-3];

        // Write address and data are taken independently, in either order.
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.awHave = 1'b1;
            st_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.wHave = 1'b1;
            st_next.wData = s_axi_wdata;
            st_next.wStrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // A write lands only when both halves are held and the previous response has been taken.
        doWrite   = st_reg.awHave && st_reg.wHave && !st_reg.bvalid;
        hitCtrl   = adcods_hit(st_reg.awAddr, ADDR_CTRL);
        hitPhase  = adcods_hit(st_reg.awAddr, ADDR_PHASE);
        if (doWrite) begin
            st_next.awHave = 1'b0;
            st_next.wHave  = 1'b0;
            st_next.bvalid = 1'b1;
            // The status word is read-only, so a write to it is answered with an error and changes nothing.
            st_next.bresp  = (hitCtrl || hitPhase) ? RESP_OKAY : RESP_SLVERR;
            if (hitCtrl && st_reg.wStrb[0]) begin
                st_next.ctrl = st_reg.wData[CTRL_GRAY_BIT:CTRL_TRISTATE_BIT];
            end
            if (hitPhase && st_reg.wStrb[0]) begin
                st_next.phase = st_reg.wData[PHASE_W-1:0];
            end
        end
        // Address and data channels stay closed until the response has been taken.
        st_next.awready = !st_next.awHave && !st_next.bvalid;
        st_next.wready  = !st_next.wHave && !st_next.bvalid;

        // Read channel: one read under way at a time.
        if (s_axi_rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        // An unmapped offset reads as zero and answers with an error.
        hitStatus = adcods_hit(s_axi_araddr, ADDR_STATUS);
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            st_next.rdata  = 32'h0;
            if (adcods_hit(s_axi_araddr, ADDR_CTRL)) begin
                st_next.rdata[CTRL_GRAY_BIT:CTRL_TRISTATE_BIT] = st_reg.ctrl;
            end else if (adcods_hit(s_axi_araddr, ADDR_PHASE)) begin
                st_next.rdata[PHASE_W-1:0] = st_reg.phase;
            end else if (hitStatus) begin
                st_next.rdata[STAT_COUNT_LSB+1:STAT_COUNT_LSB] = st_reg.count;
                st_next.rdata[STAT_OUTVALID_BIT] = st_reg.outValid;
            end else begin
                st_next.rresp = RESP_SLVERR;
            end
        end
        st_next.arready = !st_next.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Synchronous reset; the readies come up high so a request may start at the first edge after release.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_reg         <= '0;
            st_reg.ctrl    <= CTRL_RESET;
            st_reg.phase   <= PHASE_RESET;
            st_reg.adcReady <= 1'b1;
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Every port is a flip-flop of the state record.
    assign adcReady      = st_reg.adcReady;
    assign dataOut       = st_reg.dataOut;
    assign dataOutOe_n   = {DATA_W{st_reg.hiZ}};
    assign outValid      = st_reg.outValid;
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rvalid  = st_reg.rvalid;

endmodule : adcods_output_stage

/* adcods_pkg.sv */
// Constants shared by the ADC output data stage: register map, field positions, reset values, timing.
// Assumes a 50 MHz master clock and a 32-bit AXI4-Lite register bus.
package adcods_pkg;

    localparam int          DATA_W        = 10;
    localparam int          FIFO_DEPTH    = 2;
    localparam int          PHASE_W       = 2;
    localparam logic [2:0]  PHASE_STEPS_M1 = 3'h3;

    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_PHASE    = 4'h4;
    localparam logic [3:0]  ADDR_STATUS   = 4'h8;

    localparam int          CTRL_TRISTATE_BIT    = 3;
    localparam int          CTRL_TRANSPARENT_BIT = 4;
    localparam int          CTRL_GRAY_BIT        = 5;
    localparam int          STAT_COUNT_LSB       = 0;
    localparam int          STAT_OUTVALID_BIT    = 2;

    localparam logic [2:0]        CTRL_RESET  = 3'h0;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : adcods_pkg

/* adcods_sink_model.sv */
// Downstream image processor model: takes driven words into a queue.
// Assumes the bench drives stall by non-blocking assignment after mclk rises.
`timescale 1ns/10ps
module adcods_sink_model
    import adcods_pkg::*;
(
    // Clock and stall control.
    input wire logic              mclk,
    input wire logic              stall,
    // Output bus of the stage.
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic [DATA_W-1:0] dataOutOe_n,
    input wire logic              outValid,
    output logic                  outReady
);
    logic [DATA_W-1:0] got[$];
    assign outReady = !stall;
    // Only a word that is actually driven onto the bus is taken.
    always @(posedge mclk) if (outValid && outReady && dataOutOe_n == '0) got.push_back(dataOut);
endmodule : adcods_sink_model

/* adcods_tb.sv */
// Self-checking bench for the ADC output data stage.
// Assumes a 50 MHz mclk and an AXI4-Lite master driven after each rising edge.
`timescale 1ns/10ps
module tb import adcods_pkg::*;;
    logic mclk = 0, nrst = 0, av = 0, stall = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic ardy, ov, ordy, awr, wr, bv, arr, rv;
    logic [DATA_W-1:0] ad = '0, dOut, oe;
    logic [3:0]        aw = '0, ar = '0, ws = 4'hF;
    logic [31:0]       wd = '0, rd;
    logic [1:0]        br, rr;
    int                miscompares = 0, n_tests = 0, cyc = 0;
    always #10 mclk = ~mclk;
    // Edges since reset release; it runs in step with the stage's pixel-period counter.
    always @(posedge mclk) cyc <= nrst ? cyc + 1 : 0;
    adcods_output_stage dut (.mclk(mclk), .nrst(nrst), .adcData(ad), .adcValid(av), .adcReady(ardy),
        .dataOut(dOut), .dataOutOe_n(oe), .outValid(ov), .outReady(ordy), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre));
    adcods_sink_model sink (.mclk(mclk), .stall(stall), .dataOut(dOut), .dataOutOe_n(oe), .outValid(ov),
        .outReady(ordy));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic lim(input int k);
        if (k >= 40) begin
            chk("wait", 0, 1);
            end_of_test();
        end
    endtask : lim
    // One bus transfer: w selects write; d is write data or expected read data.
    task automatic ax(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int k;
        if (w) begin
            aw <= a;
            wd <= d;
            awv <= 1;
            wv <= 1;
            bre <= 1;
        end else begin
            ar <= a;
            arv <= 1;
            rre <= 1;
        end
        for (k = 0; k < 40 && !(bv && bre || rv && rre); k++) begin
            @(posedge mclk);
            if (awr && awv) awv <= 0;
            if (wr && wv) wv <= 0;
            if (arr && arv) arv <= 0;
        end
        lim(k);
        chk("resp", 32'(e), 32'(w ? br : rr));
        if (!w) chk("rdata", d, rd);
        bre <= 0;
        rre <= 0;
        @(posedge mclk);
    endtask : ax
    task automatic snd(input logic [DATA_W-1:0] d);
        int k;
        logic done;
        ad <= d;
        av <= 1;
        done = 0;
        for (k = 0; k < 40 && !done; k++) begin
            @(posedge mclk);
            done = ardy;
        end
        lim(done ? 0 : k);
    endtask : snd
    task automatic take(input logic [DATA_W-1:0] e);
        int k;
        for (k = 0; k < 40 && sink.got.size() == 0; k++) @(posedge mclk);
        lim(k);
        chk("word", 32'(e), 32'(sink.got.pop_front()));
    endtask : take
    task automatic t_regs;
        ax(0, ADDR_CTRL, 32'h0, RESP_OKAY);
        ax(0, ADDR_PHASE, 32'h0, RESP_OKAY);
        ax(1, ADDR_STATUS, 32'h1, RESP_SLVERR);
        ax(0, 4'hC, 32'h0, RESP_SLVERR);
        ax(1, ADDR_PHASE, 32'h3, RESP_OKAY);
        ax(0, ADDR_PHASE, 32'h3, RESP_OKAY);
        ws <= 4'h0;
        ax(1, ADDR_PHASE, 32'h1, RESP_OKAY);
        ws <= 4'hF;
        ax(0, ADDR_PHASE, 32'h3, RESP_OKAY);
        $display("test regs done");
    endtask : t_regs
    task automatic t_buf;
        int k;
        stall <= 1;
        snd(10'h001);
        av <= 0;
        for (k = 0; k < 40 && !ov; k++) @(posedge mclk);
        lim(k);
        chk("phase", 32'h3, 32'((cyc - 1) % (PHASE_STEPS_M1 + 1)));
        snd(10'h2F0);
        snd(10'h3FF);
        av <= 0;
        repeat (8) @(posedge mclk);
        chk("adcReady", 0, ardy);
        ax(0, ADDR_STATUS, 32'h6, RESP_OKAY);
        stall <= 0;
        take(10'h001);
        take(10'h2F0);
        take(10'h3FF);
        $display("test latched done");
    endtask : t_buf
    task automatic t_gray;
        ax(1, ADDR_CTRL, 32'h20, RESP_OKAY);
        snd(10'h3FF);
        snd(10'h2AA);
        av <= 0;
        take(10'h200);
        take(10'h3FF);
        $display("test gray done");
    endtask : t_gray
    task automatic t_trans;
        int k;
        ax(1, ADDR_CTRL, 32'h10, RESP_OKAY);
        snd(10'h155);
        av <= 0;
        for (k = 0; k < 40 && !ov; k++) @(negedge mclk);
        chk("latency", 2, k);
        take(10'h155);
        ax(1, ADDR_CTRL, 32'h8, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk("oe", 32'h3FF, 32'(oe));
        ax(1, ADDR_CTRL, 32'h0, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk("oe", 0, 32'(oe));
        $display("test transparent and release done");
    endtask : t_trans
    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1;
        @(posedge mclk);
        t_regs();
        t_buf();
        t_gray();
        t_trans();
        end_of_test();
    end
endmodule : tb
